// ==== i2c_status_irq.sv ====
// status flags, interrupt enables and apb register file of the serial bus controller
// assumes the byte shifter shares pclk and reports events as one-cycle pulses
//
// Function
// - stretch flag holds scl low until cleared
// - master timeout on start fail or long low
// - address match against own slave address
// - arbitration loss sets flag, clears master select
// - nack from receiver sets nack flag
// - broadcast flag only when enabled and received
// - second unread received byte sets overrun
// - buffer read clears overrun, zero write doesnt
// - read-only bit shows scl level
// - module busy from operation start to end
// - bus occupied between start and stop
// - software clears flags, some settable by software
// - stretch, arbitration, nack flags hardware-set only
// - enable bits gate matching flags to interrupt
// - broadcast enable gates response and flag
// - stretch enable holds scl at chosen point
// - unused bits read as zero
// - enable register read/write, resets to zero
// - start flag on start or repeated start
// - transmit done after byte and acknowledge
// - receive ready on full byte, hardware only
module i2c_status_irq #(
	parameter int TO_W = 16
) (
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	// apb slave
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [7:0]                paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	// bus lines, scl is open drain
	input  wire logic                      scl_i,
	input  wire logic                      sda_i,
	output logic                           scl_o,
	output logic                           scl_oe,
	// byte shifter side
	input  wire i2c_status_pkg::shift_evt_t evt,
	output logic                           module_enable,
	output logic                           master_select,
	output logic [i2c_status_pkg::STRS_W-1:0] stretch_point_select,
	output logic                           bcast_respond,
	output logic                           own_addr_ack,
	// cpu interrupt request
	output logic                           irq
);
	localparam int FLAG_BITS = i2c_status_pkg::FLAG_N; // number of stored event flags

	logic [15:0]     status_q;     // flag bits 9:0 are stored here
	logic [15:0]     status_rd;    // assembled read view
	logic [15:0]     irq_en_q;     // serial_bus_irq_enable
	logic [6:0]      own_addr_q;   // own_slave_address
	logic [TO_W-1:0] timeout_q;    // timeout_limit in pclk cycles
	logic [7:0]      rx_buf_q;     // last received byte
	logic            rx_unread_q;  // a byte waits for the cpu
	logic            mbusy_q;      // module_busy
	logic            bus_occ_q;    // bus_occupied
	logic            mst_q;        // master_select
	logic            en_q;         // module_enable
	logic [i2c_status_pkg::STRS_W-1:0] strs_q;
	logic            scl_level;
	logic            start_det;
	logic            stop_det;
	logic            low_expired;
	logic            wr_acc;       // write access phase
	logic            rd_acc;       // read access phase
	logic            setup;        // setup phase
	logic [5:0]      idx;          // register index from the address
	logic            idx_ok;       // address hits a register
	logic [15:0]     wdata16;
	logic [FLAG_BITS-1:0] hw_set;  // hardware set requests
	logic            to_event;     // timeout this cycle
	logic            buf_read;     // cpu reads the data buffer

	// line synchroniser and start/stop finder
	line_watch u_line (
		.pclk      (pclk),
		.presetn   (presetn),
		.scl_pin   (scl_i),
		.sda_pin   (sda_i),
		.scl_level (scl_level),
		.start_det (start_det),
		.stop_det  (stop_det)
	);

	// measures how long scl is held low while we are master
	scl_low_timer #(
		.CNT_W (TO_W)
	) u_timer (
		.pclk      (pclk),
		.presetn   (presetn),
		.run       (mst_q & en_q),
		.scl_level (scl_level),
		.limit     (timeout_q),
		.expired   (low_expired)
	);

	// apb decode; zero-wait slave, read data captured in the setup cycle
	assign setup   = psel & ~penable;
	assign wr_acc  = psel & penable & pwrite & idx_ok;
	assign rd_acc  = psel & penable & ~pwrite & idx_ok;
	assign idx     = paddr[7:2];
	assign wdata16 = pwdata[15:0];
	assign pready  = 1'b1;
	// unmapped or misaligned addresses answer with an error and no effect
	assign pslverr = psel & penable & ~idx_ok;

	// which indices exist
	always_comb begin
		idx_ok = 1'b0;
		if (paddr[1:0] == 2'h0) begin
			unique case (idx)
				i2c_status_pkg::IDX_DATA_BUF,
				i2c_status_pkg::IDX_STATUS,
				i2c_status_pkg::IDX_IRQ_EN,
				i2c_status_pkg::IDX_CTRL,
				i2c_status_pkg::IDX_OWN_ADDR,
				i2c_status_pkg::IDX_TIMEOUT: idx_ok = 1'b1;
				default:                     idx_ok = 1'b0;
			endcase
		end
	end

	assign buf_read = rd_acc && idx == i2c_status_pkg::IDX_DATA_BUF;

	// timeout only counts in master mode
	assign to_event = mst_q & (evt.start_fail | low_expired);

	// hardware set requests for every flag
	always_comb begin
		hw_set = '0;
		hw_set[i2c_status_pkg::ST_START]   = start_det & en_q;
		hw_set[i2c_status_pkg::ST_TX_DONE] = evt.tx_ack_done;
		hw_set[i2c_status_pkg::ST_RX_RDY]  = evt.rx_done;
		// stretch only when enabled, at the point the shifter reports
		hw_set[i2c_status_pkg::ST_STRETCH] =
			evt.stretch_point & irq_en_q[i2c_status_pkg::IE_STRETCH_EN];
		hw_set[i2c_status_pkg::ST_TIMEOUT] = to_event;
		hw_set[i2c_status_pkg::ST_ADDR]    =
			evt.addr_valid && evt.addr == own_addr_q;
		hw_set[i2c_status_pkg::ST_ARB]     = evt.arb_lost & mst_q;
		hw_set[i2c_status_pkg::ST_NACK]    = evt.tx_ack_done & evt.tx_nack;
		hw_set[i2c_status_pkg::ST_BCAST]   = evt.addr_valid
			&& evt.addr == i2c_status_pkg::BCAST_ADDR
			&& irq_en_q[i2c_status_pkg::IE_BCAST_EN];
		// a byte arriving while the previous one is unread is an overrun
		hw_set[i2c_status_pkg::ST_OVERRUN] = evt.rx_done & rx_unread_q;
	end

	// flag storage; a hardware set always wins over a clear in the same cycle
	generate
		for (genvar b = 0; b < FLAG_BITS; b++) begin : g_flag
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					status_q[b] <= 1'b0;
				end else if (hw_set[b]) begin
					status_q[b] <= 1'b1;
				end else if (wr_acc && idx == i2c_status_pkg::IDX_STATUS) begin
					// zero clears where allowed, one sets only where allowed
					if (wdata16[b] && i2c_status_pkg::SW_SET_MASK[b]) begin
						status_q[b] <= 1'b1;
					end else if (!wdata16[b] && i2c_status_pkg::SW_CLR_MASK[b]) begin
						status_q[b] <= 1'b0;
					end
				end else if (b == i2c_status_pkg::ST_OVERRUN && buf_read) begin
					status_q[b] <= 1'b0;
				end
			end
		end
	endgenerate

	// upper status bits are not stored as flags
	assign status_q[15:FLAG_BITS] = '0;

	// read view: live scl, busy bits, reserved as zero
	always_comb begin
		status_rd = '0;
		status_rd[FLAG_BITS-1:0]         = status_q[FLAG_BITS-1:0];
		status_rd[i2c_status_pkg::ST_SCL]   = scl_level;
		status_rd[i2c_status_pkg::ST_MBUSY] = mbusy_q;
		status_rd[i2c_status_pkg::ST_BUS]   = bus_occ_q;
	end

	// interrupt enables, unused bits never stored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_en_q <= i2c_status_pkg::REG_RESET;
		end else if (wr_acc && idx == i2c_status_pkg::IDX_IRQ_EN) begin
			irq_en_q <= wdata16 & i2c_status_pkg::IE_RW_MASK;
		end
	end

	// control: enable, master select, stretch point
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_q   <= 1'b0;
			mst_q  <= 1'b0;
			strs_q <= '0;
		end else begin
			if (wr_acc && idx == i2c_status_pkg::IDX_CTRL) begin
				en_q   <= wdata16[i2c_status_pkg::CTRL_EN];
				mst_q  <= wdata16[i2c_status_pkg::CTRL_MST];
				strs_q <= wdata16[i2c_status_pkg::CTRL_STRS +: i2c_status_pkg::STRS_W];
			end
			// losing arbitration drops us to slave even against a same-cycle write
			if (evt.arb_lost && mst_q) begin
				mst_q <= 1'b0;
			end
		end
	end

	// own address and timeout limit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			own_addr_q <= '0;
			timeout_q  <= '0;
		end else if (wr_acc) begin
			if (idx == i2c_status_pkg::IDX_OWN_ADDR) begin
				own_addr_q <= wdata16[6:0];
			end
			if (idx == i2c_status_pkg::IDX_TIMEOUT) begin
				timeout_q <= wdata16[TO_W-1:0];
			end
		end
	end

	// receive byte and unread marker; a new byte beats a same-cycle read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_buf_q    <= '0;
			rx_unread_q <= 1'b0;
		end else if (evt.rx_done) begin
			// newest byte kept; the older unread one is lost on overrun
			rx_buf_q    <= evt.rx_data;
			rx_unread_q <= 1'b1;
		end else if (buf_read) begin
			rx_unread_q <= 1'b0;
		end
	end

	// module busy spans one shifter operation or ends on master timeout
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mbusy_q <= 1'b0;
		end else if (evt.op_start) begin
			mbusy_q <= 1'b1;
		end else if (evt.op_done || to_event) begin
			mbusy_q <= 1'b0;
		end
	end

	// bus occupancy from line conditions; forced idle while disabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_occ_q <= 1'b0;
		end else if (!en_q) begin
			bus_occ_q <= 1'b0;
		end else if (start_det) begin
			bus_occ_q <= 1'b1;
		end else if (stop_det) begin
			bus_occ_q <= 1'b0;
		end
	end

	// read data registered in the setup cycle so prdata comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (setup && !pwrite) begin
			prdata <= '0;
			unique case (idx)
				i2c_status_pkg::IDX_DATA_BUF: prdata[7:0]  <= rx_buf_q;
				i2c_status_pkg::IDX_STATUS:   prdata[15:0] <= status_rd;
				i2c_status_pkg::IDX_IRQ_EN:   prdata[15:0] <= irq_en_q;
				i2c_status_pkg::IDX_CTRL: begin
					prdata[i2c_status_pkg::CTRL_EN]  <= en_q;
					prdata[i2c_status_pkg::CTRL_MST] <= mst_q;
					prdata[i2c_status_pkg::CTRL_STRS +: i2c_status_pkg::STRS_W] <= strs_q;
				end
				i2c_status_pkg::IDX_OWN_ADDR: prdata[6:0] <= own_addr_q;
				i2c_status_pkg::IDX_TIMEOUT:  prdata[TO_W-1:0] <= timeout_q;
				default:                      prdata <= '0;
			endcase
		end
	end

	// scl is pulled low only while the stretch flag stands
	assign scl_o  = 1'b0;
	assign scl_oe = status_q[i2c_status_pkg::ST_STRETCH];

	// shifter-facing controls
	assign module_enable        = en_q;
	assign master_select        = mst_q;
	assign stretch_point_select = strs_q;
	// without the enable the broadcast address is simply not acknowledged
	assign bcast_respond = evt.addr_valid && evt.addr == i2c_status_pkg::BCAST_ADDR
		&& irq_en_q[i2c_status_pkg::IE_BCAST_EN];
	assign own_addr_ack  = evt.addr_valid && evt.addr == own_addr_q;

	// level request: any flag whose enable is set; broadcast flag uses its
	// enable bit too, since that bit also gates the flag itself
	assign irq = |(status_q[FLAG_BITS-1:0] & irq_en_q[FLAG_BITS-1:0]);
endmodule

// ==== i2c_status_pkg.sv ====
// shared constants and types for the serial bus status and interrupt-enable block
// assumes a 32-bit apb slave port and an external byte shifter on the same clock
package i2c_status_pkg;
	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_DATA_BUF = 6'h04; // serial_data_buffer
	localparam logic [5:0] IDX_STATUS   = 6'h05; // serial_bus_event_status
	localparam logic [5:0] IDX_IRQ_EN   = 6'h06; // serial_bus_irq_enable
	localparam logic [5:0] IDX_CTRL     = 6'h0A; // enable, master, stretch point
	localparam logic [5:0] IDX_OWN_ADDR = 6'h0B; // own_slave_address
	localparam logic [5:0] IDX_TIMEOUT  = 6'h0C; // timeout_limit
	// status bit positions
	localparam int ST_START   = 0;
	localparam int ST_TX_DONE = 1;
	localparam int ST_RX_RDY  = 2;
	localparam int ST_STRETCH = 3;
	localparam int ST_TIMEOUT = 4;
	localparam int ST_ADDR    = 5;
	localparam int ST_ARB     = 6;
	localparam int ST_NACK    = 7;
	localparam int ST_BCAST   = 8;
	localparam int ST_OVERRUN = 9;
	localparam int ST_SCL     = 10;
	localparam int ST_MBUSY   = 14;
	localparam int ST_BUS     = 15;
	localparam int FLAG_N     = 10;
	// enable-register bits with roles beyond the per-flag irq enables
	localparam int IE_BCAST_EN   = 8;
	localparam int IE_STRETCH_EN = 10;
	// software write behaviour of the flag bits
	localparam logic [15:0] SW_SET_MASK = 16'h0333; // writing one raises these
	localparam logic [15:0] SW_CLR_MASK = 16'h01FF; // writing zero clears these
	localparam logic [15:0] IE_RW_MASK  = 16'h07FF;
	localparam logic [15:0] REG_RESET   = 16'h0000;
	// control register fields
	localparam int CTRL_EN   = 0;
	localparam int CTRL_MST  = 1;
	localparam int CTRL_STRS = 2;
	localparam int STRS_W    = 2;
	localparam logic [6:0] BCAST_ADDR = 7'h00;
	// per-cycle events from the byte shifter, all one-cycle pulses
	typedef struct packed {
		logic       op_start;
		logic       op_done;
		logic       start_fail;
		logic       addr_valid;
		logic [6:0] addr;
		logic       tx_ack_done;
		logic       tx_nack;
		logic       rx_done;
		logic [7:0] rx_data;
		logic       stretch_point;
		logic       arb_lost;
	} shift_evt_t;
endpackage

// ==== line_watch.sv ====
// synchronises the bus lines and finds start and stop conditions
// assumes scl and sda arrive asynchronously from the pins
module line_watch (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic scl_pin,
	input  wire logic sda_pin,
	output logic      scl_level,
	output logic      start_det,
	output logic      stop_det
);
	logic [1:0] scl_sync_q; // two-stage synchroniser, stage 0 read by stage 1 only
	logic [1:0] sda_sync_q;
	logic       sda_prev_q; // last settled sda level

	// idle bus is high, so the synchronisers reset high to avoid false starts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_sync_q <= 2'h3;
			sda_sync_q <= 2'h3;
			sda_prev_q <= 1'b1;
		end else begin
			scl_sync_q <= {scl_sync_q[0], scl_pin};
			sda_sync_q <= {sda_sync_q[0], sda_pin};
			sda_prev_q <= sda_sync_q[1];
		end
	end

	assign scl_level = scl_sync_q[1];
	// sda falling while scl high is a start, rising is a stop
	assign start_det = scl_sync_q[1] & sda_prev_q & ~sda_sync_q[1];
	assign stop_det  = scl_sync_q[1] & ~sda_prev_q & sda_sync_q[1];
endmodule

// ==== scl_low_timer.sv ====
// counts pclk cycles of scl low and pulses once when the limit is reached
// assumes scl_level is already synchronised; a limit of zero disables it
module scl_low_timer #(
	parameter int CNT_W = 16
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             run,
	input  wire logic             scl_level,
	input  wire logic [CNT_W-1:0] limit,
	output logic                  expired
);
	logic [CNT_W-1:0] cnt_q; // saturating low-time count
	logic [CNT_W-1:0] cnt_d;

	// restart on every high phase; saturate so the pulse fires once
	always_comb begin
		cnt_d = cnt_q;
		if (!run || scl_level || limit == '0) begin
			cnt_d = '0;
		end else if (cnt_q != limit) begin
			cnt_d = cnt_q + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q   <= '0;
			expired <= 1'b0;
		end else begin
			cnt_q   <= cnt_d;
			expired <= (cnt_d == limit) && (cnt_q != limit) && (limit != '0);
		end
	end
endmodule

// ==== i2c_status_irq_chk.sv ====
// port-level checker for the serial bus status and irq-enable block
// assumes byte addresses on apb and one-cycle shifter event pulses
module i2c_status_irq_chk (
	input wire logic                       pclk,
	input wire logic                       presetn,
	input wire logic                       psel,
	input wire logic                       penable,
	input wire logic                       pwrite,
	input wire logic [7:0]                 paddr,
	input wire logic [31:0]                pwdata,
	input wire logic [31:0]                prdata,
	input wire logic                       scl_i,
	input wire logic                       scl_o,
	input wire logic                       scl_oe,
	input wire i2c_status_pkg::shift_evt_t evt,
	input wire logic                       master_select,
	input wire logic                       bcast_respond,
	input wire logic                       own_addr_ack,
	input wire logic                       irq
);
	localparam logic [7:0] ad_st = {i2c_status_pkg::IDX_STATUS, 2'b00};
	localparam logic [7:0] ad_ie = {i2c_status_pkg::IDX_IRQ_EN, 2'b00};
	localparam logic [7:0] ad_ct = {i2c_status_pkg::IDX_CTRL, 2'b00};
	logic rd_st; // setup cycle of a status read
	logic rd_ie; // setup cycle of an enable read
	logic st_wr; // access cycle of a status write
	logic ct_wr; // access cycle of a control write
	assign rd_st = psel && !penable && !pwrite && paddr == ad_st;
	assign rd_ie = psel && !penable && !pwrite && paddr == ad_ie;
	assign st_wr = psel && penable && pwrite && paddr == ad_st;
	assign ct_wr = psel && penable && pwrite && paddr == ad_ct;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// a software write of one must never start a stretch
	a_stretch_cause: assert property ($rose(scl_oe) |-> $past(evt.stretch_point))
		else $error("scl held low without a stretch point");
	// release only by a status write with the stretch bit zero
	a_stretch_hold: assert property ($fell(scl_oe) |-> $past(st_wr && !pwdata[3]))
		else $error("scl released without software clear");
	a_scl_drive_low: assert property (scl_oe |-> !scl_o)
		else $error("scl driven high");
	a_arb_clears_mst: assert property (evt.arb_lost && master_select |=> !master_select)
		else $error("master select kept after arbitration loss");
	a_mst_drop_cause: assert property ($fell(master_select) |-> $past(evt.arb_lost || ct_wr))
		else $error("master select dropped without cause");
	a_bcast_gate: assert property (bcast_respond |-> evt.addr_valid && evt.addr == 7'h00)
		else $error("broadcast response without broadcast address");
	a_own_ack_cause: assert property (own_addr_ack |-> evt.addr_valid)
		else $error("address ack outside address stage");
	a_st_reserved: assert property (rd_st |=> prdata[13:11] == 3'h0)
		else $error("status reserved bits not zero");
	a_ie_reserved: assert property (rd_ie |=> prdata[31:11] == 21'h0)
		else $error("enable reserved bits not zero");
	// scl steady high for four edges must read as one
	a_scl_level: assert property (rd_st && scl_i && $past(scl_i) && $past(scl_i, 2) && $past(scl_i, 3)
		|=> prdata[10])
		else $error("scl level bit low while scl high");
	c_stretch: cover property ($rose(scl_oe));
	c_arb: cover property (evt.arb_lost && master_select);
	c_bcast: cover property (bcast_respond);
	c_irq: cover property ($rose(irq));
endmodule

bind i2c_status_irq i2c_status_irq_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .scl_i, .scl_o, .scl_oe, .evt, .master_select, .bcast_respond,
	.own_addr_ack, .irq);

// ==== i2c_bus_peer.sv ====
// model of the other parties on the two-wire bus: start and stop only
// assumes pull-ups, so a released line reads high; clock idle outside frames
module i2c_bus_peer (
	output logic scl_d,
	output logic sda_d
);
	timeunit 1ns;
	timeprecision 1ps;
	// both lines released at time zero
	initial begin
		scl_d = 1'b1;
		sda_d = 1'b1;
	end
	// sda falls with scl high, then scl is held low (80 ns half period)
	task automatic start();
		#80 sda_d = 1'b0;
		#80 scl_d = 1'b0;
	endtask
	// sda rises while scl is high
	task automatic stop();
		#80 sda_d = 1'b0;
		#80 scl_d = 1'b1;
		#80 sda_d = 1'b1;
	endtask
endmodule

// ==== i2c_status_irq_tb.sv ====
// self-checking bench for the serial bus status and irq-enable block
// assumes the peer model on scl and sda; the bench plays the byte shifter
module i2c_status_irq_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] ad_buf = {i2c_status_pkg::IDX_DATA_BUF, 2'b00};
	localparam logic [7:0] ad_st  = {i2c_status_pkg::IDX_STATUS, 2'b00};
	localparam logic [7:0] ad_ie  = {i2c_status_pkg::IDX_IRQ_EN, 2'b00};
	localparam logic [7:0] ad_ct  = {i2c_status_pkg::IDX_CTRL, 2'b00};
	localparam logic [7:0] ad_own = {i2c_status_pkg::IDX_OWN_ADDR, 2'b00};
	localparam logic [7:0] ad_to  = {i2c_status_pkg::IDX_TIMEOUT, 2'b00};
	logic                       pclk    = 1'b0;
	logic                       presetn = 1'b0;
	logic                       psel    = 1'b0;
	logic                       penable = 1'b0;
	logic                       pwrite  = 1'b0;
	logic [7:0]                 paddr   = 8'h00;
	logic [31:0]                pwdata  = 32'h0;
	i2c_status_pkg::shift_evt_t evt     = '0;
	i2c_status_pkg::shift_evt_t ev;
	logic [31:0]                prdata, r;
	logic [1:0]                 sps;
	logic                       pready, pslverr, scl_o, scl_oe, men, mst, bresp, aack, irq, e;
	wire                        scl_d, sda_d, scl_w;
	int                         n_errors = 0;
	int                         tests_run = 0;
	int                         m_ie, m_mst, m_own, m_unr, m_ovr, m_bsy, m_buf, k, v;
	initial forever #2 pclk = ~pclk;
	// open-drain scl: the block only ever pulls low
	assign scl_w = scl_d & ~(scl_oe & ~scl_o);
	i2c_bus_peer peer (.scl_d(scl_d), .sda_d(sda_d));
	i2c_status_irq #(.TO_W(16)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .scl_i(scl_w), .sda_i(sda_d), .scl_o(scl_o),
		.scl_oe(scl_oe), .evt(evt), .module_enable(men), .master_select(mst),
		.stretch_point_select(sps), .bcast_respond(bresp), .own_addr_ack(aack), .irq(irq));
	// verdict and end of run
	task automatic close_out();
		$display("checks %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			n_errors++;
			close_out();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// pulse one shifter event, compare flags and irq with the model, clear
	task automatic fl(input i2c_status_pkg::shift_evt_t x);
		int f;
		@(posedge pclk);
		evt <= x;
		@(posedge pclk);
		// the address answers stand only while the event pulse is held
		chk(bresp, x.addr_valid && x.addr == 7'h00 && m_ie[8]);
		chk(aack, x.addr_valid && x.addr == m_own[6:0]);
		evt <= '0;
		f = 0;
		if (x.tx_ack_done) f |= 32'h0002;
		if (x.rx_done) f |= 32'h0004;
		if (x.stretch_point && m_ie[10]) f |= 32'h0008;
		if (x.start_fail && m_mst) f |= 32'h0010;
		if (x.addr_valid && x.addr == m_own[6:0]) f |= 32'h0020;
		if (x.arb_lost && m_mst) f |= 32'h0040;
		// a nack is the answer bit of a finished transmit
		if (x.tx_ack_done && x.tx_nack) f |= 32'h0080;
		if (x.addr_valid && x.addr == 7'h00 && m_ie[8]) f |= 32'h0100;
		if (x.rx_done && m_unr) m_ovr = 1;
		if (x.rx_done) m_unr = 1;
		if (x.rx_done) m_buf = x.rx_data;
		if (x.op_start) m_bsy = 1;
		// a master timeout aborts the running operation too
		if (x.op_done || (x.start_fail && m_mst)) m_bsy = 0;
		if (x.arb_lost) m_mst = 0;
		f |= (m_ovr << 9) | (m_bsy << 14);
		repeat (4) @(posedge pclk);
		f |= int'(scl_w) << 10;
		chk(irq, (f & m_ie & 32'h03FF) != 0);
		apb(1'b0, ad_st, 32'h0);
		chk(r, f);
		apb(1'b1, ad_st, 32'h0);
		@(posedge pclk);
		chk(mst, m_mst);
		chk(scl_oe, 0);
	endtask
	initial begin
		#400000;
		n_errors++;
		close_out();
	end
	initial begin
		void'($urandom(97354));
		{m_ie, m_mst, m_unr, m_ovr, m_bsy, m_buf} = '0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, ad_ie, 32'h0);
		chk(r, 32'h0);
		apb(1'b0, ad_st, 32'h0);
		chk(r, 32'h0400);
		apb(1'b0, 8'h00, 32'h0);
		chk(e, 1);
		apb(1'b1, ad_ie, 32'hFFFFFFFF);
		apb(1'b0, ad_ie, 32'h0);
		chk(r, 32'h07FF);
		apb(1'b1, ad_st, 32'h03FF);
		apb(1'b0, ad_st, 32'h0);
		chk(r, 32'h0733);
		chk(irq, 1);
		apb(1'b1, ad_ie, 32'h0);
		apb(1'b1, ad_st, 32'h0);
		apb(1'b0, ad_st, 32'h0);
		chk(r, 32'h0600);
		chk(irq, 0);
		apb(1'b0, ad_buf, 32'h0);
		apb(1'b0, ad_st, 32'h0);
		chk(r, 32'h0400);
		$display("test registers done");
		m_ie = 32'h0500;
		m_own = ($urandom % 127) + 1;
		apb(1'b1, ad_ie, m_ie);
		apb(1'b1, ad_own, m_own);
		apb(1'b1, ad_ct, 32'h1);
		for (int i = 0; i < 80; i++) begin
			k = (i < 4) ? i + 12 : $urandom % 12;
			v = $urandom;
			ev = '0;
			ev.addr = v[0] ? m_own[6:0] : 7'h00;
			ev.rx_data = v[15:8];
			case (k)
				0: ev.op_start = 1'b1;
				1: ev.op_done = 1'b1;
				2: ev.start_fail = 1'b1;
				3, 12: ev.stretch_point = 1'b1;
				4, 13: ev.addr_valid = 1'b1;
				5: ev.tx_ack_done = 1'b1;
				6: begin
					// a nack only counts together with the end of a transmit
					ev.tx_ack_done = 1'b1;
					ev.tx_nack = 1'b1;
				end
				7, 14, 15: ev.rx_done = 1'b1;
				8: ev.arb_lost = 1'b1;
				9: begin
					apb(1'b0, ad_buf, 32'h0);
					chk(r[7:0], m_buf);
					m_ovr = 0;
					m_unr = 0;
				end
				10: begin
					apb(1'b1, ad_ct, {28'h0, v[3:1], 1'b1});
					m_mst = v[1];
					@(posedge pclk);
					chk(sps, v[3:2]);
				end
				default: begin
					m_ie = v & 32'h07FF;
					apb(1'b1, ad_ie, v);
					apb(1'b0, ad_ie, 32'h0);
					chk(r, m_ie);
				end
			endcase
			if (k < 9 || k > 11) fl(ev);
		end
		$display("test events done");
		apb(1'b0, ad_buf, 32'h0);
		apb(1'b1, ad_to, 32'd20);
		apb(1'b1, ad_ct, 32'h3);
		apb(1'b1, ad_st, 32'h0);
		// keep the line changes off the pclk edges
		#1;
		peer.start();
		#400;
		apb(1'b0, ad_st, 32'h0);
		chk(r, 32'h8011);
		apb(1'b1, ad_st, 32'h0);
		#1;
		peer.stop();
		// the stop needs the synchroniser and one more edge to reach the bit
		repeat (4) @(posedge pclk);
		apb(1'b0, ad_st, 32'h0);
		chk(r, 32'h0400);
		$display("test bus lines done");
		close_out();
	end
endmodule
